// *** include/acirq_map.svh ***
// register map, field positions, reset values and codes of the comparator
`ifndef ACIRQ_MAP_SVH
`define ACIRQ_MAP_SVH

`define ACIRQ_CS_OFF 8'h00
`define ACIRQ_CHAN_OFF 8'h04
`define ACIRQ_EVT_OFF 8'h08
`define ACIRQ_MASK_OFF 8'h0c

`define ACIRQ_CS_DIS 7
`define ACIRQ_CS_BG 6
`define ACIRQ_CS_OUT 5
`define ACIRQ_CS_FLAG 4
`define ACIRQ_CS_IE 3
`define ACIRQ_CS_MUXEN 2

`define ACIRQ_CS_RST 8'h00
`define ACIRQ_CHAN_RST 5'h00
`define ACIRQ_EVT_RST 2'h0
`define ACIRQ_MASK_RST 2'h0

`define ACIRQ_MODE_TOGGLE 2'h0
`define ACIRQ_MODE_RSVD 2'h1
`define ACIRQ_MODE_FALL 2'h2
`define ACIRQ_MODE_RISE 2'h3

`define ACIRQ_CHAN_MAX 4'ha
`define ACIRQ_EVT_CMP 0
`define ACIRQ_EVT_UNDEF 1

`endif

// *** include/acirq_pkg.sv ***
// types shared by the comparator control modules
`default_nettype none
package acirq_pkg;
  typedef struct packed {
    logic cmp_disable;
    logic bandgap_sel;
    logic irq_flag;
    logic irq_enable;
    logic mux_enable;
    logic [1:0] irq_mode;
    logic [4:0] chan_sel;
    logic [3:0] neg_chan;
    logic neg_use_chan;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } acirq_state_type;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } acirq_sync_type;

  typedef struct packed {
    logic prev;
  } acirq_edge_type;
endpackage
`default_nettype wire

// *** include/acirq_if.sv ***
// link between the control core and its event detector
`default_nettype none
interface acirq_if;
  logic sample;
  logic [1:0] mode;
  logic event_pulse;

  modport core (output sample, output mode, input event_pulse);
  modport detect (input sample, input mode, output event_pulse);
endinterface
`default_nettype wire

// *** verilog/acirq_sync.sv ***
// two flip-flop synchroniser for the analog comparator result
`default_nettype none
module acirq_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic sync_out
);
  acirq_pkg::acirq_sync_type s_reg;
  acirq_pkg::acirq_sync_type s_next;

  always_comb begin
    s_next = s_reg;
    s_next.stage1 = async_in;
    s_next.stage2 = s_reg.stage1;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stage2;
endmodule
`default_nettype wire

// *** verilog/acirq_edge.sv ***
// edge and toggle detector with interrupt mode decode
`default_nettype none
`include "acirq_map.svh"
module acirq_edge (
  input wire logic clk_in,
  input wire logic rst_in,
  acirq_if.detect link
);
  acirq_pkg::acirq_edge_type e_reg;
  acirq_pkg::acirq_edge_type e_next;
  logic rise;
  logic fall;

  always_comb begin
    e_next = e_reg;
    e_next.prev = link.sample;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      e_reg <= '0;
    end else begin
      e_reg <= e_next;
    end
  end

  assign rise = link.sample & ~e_reg.prev;
  assign fall = ~link.sample & e_reg.prev;

  always_comb begin
    unique case (link.mode)
      `ACIRQ_MODE_TOGGLE: link.event_pulse = rise | fall;
      `ACIRQ_MODE_RSVD: link.event_pulse = 1'b0;
      `ACIRQ_MODE_FALL: link.event_pulse = fall;
      `ACIRQ_MODE_RISE: link.event_pulse = rise;
    endcase
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_rise_only: assert property (
    link.mode == `ACIRQ_MODE_RISE && link.event_pulse
      |-> link.sample && !$past(link.sample))
    else $error("rise mode fired without a rising sample");

  chk_reserved_quiet: assert property (
    link.mode == `ACIRQ_MODE_RSVD |-> !link.event_pulse)
    else $error("reserved mode produced an event");
endmodule
`default_nettype wire

// *** verilog/acirq_top.sv ***
// analog comparator control, interrupt logic and apb register slave
`default_nettype none
`include "acirq_map.svh"
module acirq_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic cmp_result_in,
  input wire logic converter_enable_in,
  input wire logic global_irq_enable_in,
  input wire logic irq_vector_ack_in,
  output logic comparator_disable_out,
  output logic bandgap_positive_select_out,
  output logic neg_use_channel_out,
  output logic [3:0] neg_channel_out,
  output logic pin_change_suppress_out,
  output logic irq_request_out,
  output logic irq_out
);
  acirq_pkg::acirq_state_type s_reg;
  acirq_pkg::acirq_state_type s_next;

  acirq_if link ();

  logic cmp_sync;
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic [7:0] cs_view;
  logic [31:0] rd_mux;
  logic flag_clear;
  localparam logic [7:0] cs_rst = `ACIRQ_CS_RST;

  acirq_sync u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(cmp_result_in),
    .sync_out(cmp_sync)
  );

  acirq_edge u_edge (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .link(link)
  );

  // a powered down comparator reads low; toggling the disable bit can
  // therefore look like an edge, which is why software masks the irq first
  assign link.sample = cmp_sync & ~s_reg.cmp_disable;
  assign link.mode = s_reg.irq_mode;

  assign access = psel_in & penable_in;
  // one wait state so that read data always comes from a flip-flop
  assign done = access & s_reg.pready;
  assign wr_done = done & pwrite_in;
  assign rd_done = done & ~pwrite_in;

  always_comb begin
    unique case (paddr_in)
      `ACIRQ_CS_OFF,
      `ACIRQ_CHAN_OFF,
      `ACIRQ_EVT_OFF,
      `ACIRQ_MASK_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    cs_view = 8'h00;
    cs_view[`ACIRQ_CS_DIS] = s_reg.cmp_disable;
    cs_view[`ACIRQ_CS_BG] = s_reg.bandgap_sel;
    cs_view[`ACIRQ_CS_OUT] = link.sample;
    cs_view[`ACIRQ_CS_FLAG] = s_reg.irq_flag;
    cs_view[`ACIRQ_CS_IE] = s_reg.irq_enable;
    cs_view[`ACIRQ_CS_MUXEN] = s_reg.mux_enable;
    cs_view[1:0] = s_reg.irq_mode;
  end

  always_comb begin
    unique case (paddr_in)
      `ACIRQ_CS_OFF: rd_mux = {24'h000000, cs_view};
      `ACIRQ_CHAN_OFF: rd_mux = {27'h0000000, s_reg.chan_sel};
      `ACIRQ_EVT_OFF: rd_mux = {30'h00000000, s_reg.evt_status};
      `ACIRQ_MASK_OFF: rd_mux = {30'h00000000, s_reg.evt_mask};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // writing zero to the flag bit leaves it alone
  assign flag_clear = irq_vector_ack_in
    | (wr_done && paddr_in == `ACIRQ_CS_OFF
       && pwdata_in[`ACIRQ_CS_FLAG]);

  always_comb begin
    s_next = s_reg;
    s_next.pready = access & ~s_reg.pready;
    if (access && !s_reg.pready) begin
      s_next.prdata = rd_mux;
      s_next.pslverr = ~mapped;
    end else if (!access) begin
      s_next.pslverr = 1'b0;
    end

    if (wr_done) begin
      unique case (paddr_in)
        `ACIRQ_CS_OFF: begin
          s_next.cmp_disable = pwdata_in[`ACIRQ_CS_DIS];
          s_next.bandgap_sel = pwdata_in[`ACIRQ_CS_BG];
          s_next.irq_enable = pwdata_in[`ACIRQ_CS_IE];
          s_next.mux_enable = pwdata_in[`ACIRQ_CS_MUXEN];
          s_next.irq_mode = pwdata_in[1:0];
        end
        `ACIRQ_CHAN_OFF: begin
          s_next.chan_sel = pwdata_in[4:0];
        end
        `ACIRQ_MASK_OFF: begin
          s_next.evt_mask = pwdata_in[1:0];
        end
        default: begin
        end
      endcase
    end

    // set wins over clear so an event on the clearing edge survives
    if (flag_clear) begin
      s_next.irq_flag = 1'b0;
    end
    if (link.event_pulse) begin
      s_next.irq_flag = 1'b1;
    end

    // a read clears only the bits it returned, so late events stay
    if (rd_done && paddr_in == `ACIRQ_EVT_OFF) begin
      s_next.evt_status = s_reg.evt_status & ~s_reg.prdata[1:0];
    end
    if (link.event_pulse) begin
      s_next.evt_status[`ACIRQ_EVT_CMP] = 1'b1;
    end
    if (wr_done && paddr_in == `ACIRQ_CHAN_OFF
        && pwdata_in[3:0] > `ACIRQ_CHAN_MAX) begin
      s_next.evt_status[`ACIRQ_EVT_UNDEF] = 1'b1;
    end

    // the select register takes one clock, the mux copy one more
    s_next.neg_chan = s_reg.chan_sel[3:0];
    s_next.neg_use_chan = s_reg.mux_enable
      & ~converter_enable_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.cmp_disable <= cs_rst[`ACIRQ_CS_DIS];
      s_reg.bandgap_sel <= cs_rst[`ACIRQ_CS_BG];
      s_reg.irq_flag <= cs_rst[`ACIRQ_CS_FLAG];
      s_reg.irq_enable <= cs_rst[`ACIRQ_CS_IE];
      s_reg.mux_enable <= cs_rst[`ACIRQ_CS_MUXEN];
      s_reg.irq_mode <= cs_rst[1:0];
      s_reg.chan_sel <= `ACIRQ_CHAN_RST;
      s_reg.evt_status <= `ACIRQ_EVT_RST;
      s_reg.evt_mask <= `ACIRQ_MASK_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata_out = s_reg.prdata;
  assign pready_out = s_reg.pready;
  assign pslverr_out = s_reg.pslverr & s_reg.pready;
  assign comparator_disable_out = s_reg.cmp_disable;
  assign bandgap_positive_select_out = s_reg.bandgap_sel;
  // codes above ten pass through; the analog mux decides what they mean
  assign neg_channel_out = s_reg.neg_chan;
  assign neg_use_channel_out = s_reg.neg_use_chan;
  assign pin_change_suppress_out = ~s_reg.cmp_disable;
  assign irq_request_out = s_reg.irq_flag & s_reg.irq_enable
    & global_irq_enable_in;
  assign irq_out = |(s_reg.evt_status & s_reg.evt_mask);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_out_mirror: assert property (
    rd_done && paddr_in == `ACIRQ_CS_OFF && !s_reg.cmp_disable
      && $stable(cmp_sync)
      |-> prdata_out[`ACIRQ_CS_OUT] == cmp_sync)
    else $error("output status bit does not follow the comparator");

  chk_disable_power: assert property (
    wr_done && paddr_in == `ACIRQ_CS_OFF && pwdata_in[`ACIRQ_CS_DIS]
      |=> comparator_disable_out && !link.sample)
    else $error("disable write did not power the comparator off");

  chk_bandgap_route: assert property (
    wr_done && paddr_in == `ACIRQ_CS_OFF
      |=> bandgap_positive_select_out == $past(pwdata_in[`ACIRQ_CS_BG]))
    else $error("bandgap select not taken from the write");

  chk_flag_sets: assert property (
    link.event_pulse |=> s_reg.irq_flag)
    else $error("comparator event did not set the flag");

  chk_irq_gate: assert property (
    irq_request_out |-> s_reg.irq_flag && s_reg.irq_enable
      && global_irq_enable_in)
    else $error("irq requested without flag and both enables");

  chk_irq_raise: assert property (
    s_reg.irq_flag && s_reg.irq_enable && global_irq_enable_in
      |-> irq_request_out)
    else $error("irq not requested with flag and both enables");

  chk_vector_clear: assert property (
    irq_vector_ack_in && !link.event_pulse |=> !s_reg.irq_flag)
    else $error("vector execution did not clear the flag");

  chk_zero_keeps: assert property (
    s_reg.irq_flag && !irq_vector_ack_in && wr_done
      && !pwdata_in[`ACIRQ_CS_FLAG] |=> s_reg.irq_flag)
    else $error("writing zero cleared the flag");

  chk_neg_select: assert property (
    !s_reg.mux_enable || converter_enable_in |=> !neg_use_channel_out)
    else $error("channel used while mux off or converter on");

  chk_chan_delay: assert property (
    wr_done && paddr_in == `ACIRQ_CHAN_OFF
      |=> neg_channel_out != $past(pwdata_in[3:0]) || $past(
        s_reg.chan_sel[3:0]) == $past(pwdata_in[3:0])
      ##1 neg_channel_out == $past(pwdata_in[3:0], 2))
    else $error("channel select not delayed by one clock");

  chk_pin_suppress: assert property (
    !comparator_disable_out |-> pin_change_suppress_out)
    else $error("pin change not suppressed while comparator on");

  chk_apb_wait: assert property (
    access && !pready_out |=> pready_out && prdata_out == $past(rd_mux))
    else $error("apb answer not one wait state later");

  chk_unmapped_err: assert property (
    access && !s_reg.pready && !mapped |=> pslverr_out)
    else $error("unmapped access answered without error");

  chk_flag_w1c: assert property (
    wr_done && paddr_in == `ACIRQ_CS_OFF && pwdata_in[`ACIRQ_CS_FLAG]
      && !link.event_pulse |=> !s_reg.irq_flag)
    else $error("writing one did not clear the flag");

  chk_flag_quiet: assert property (
    !s_reg.irq_flag && !link.event_pulse |=> !s_reg.irq_flag)
    else $error("flag set without a comparator event");

  chk_toggle_fires: assert property (
    link.mode == `ACIRQ_MODE_TOGGLE && $changed(link.sample)
      |-> link.event_pulse)
    else $error("toggle mode missed an output change");

  chk_evt_sets: assert property (
    link.event_pulse |=> s_reg.evt_status[`ACIRQ_EVT_CMP])
    else $error("comparator event not recorded in status");

  chk_evt_read_clear: assert property (
    rd_done && paddr_in == `ACIRQ_EVT_OFF && !link.event_pulse
      && s_reg.prdata[`ACIRQ_EVT_CMP]
      |=> !s_reg.evt_status[`ACIRQ_EVT_CMP])
    else $error("status read did not clear the returned bit");

  chk_undef_flag: assert property (
    wr_done && paddr_in == `ACIRQ_CHAN_OFF
      && pwdata_in[3:0] > `ACIRQ_CHAN_MAX
      |=> s_reg.evt_status[`ACIRQ_EVT_UNDEF])
    else $error("undefined channel code not flagged");

  chk_mux_use: assert property (
    s_reg.mux_enable && !converter_enable_in |=> neg_use_channel_out)
    else $error("channel mux not used while enabled");

  chk_chan_follow: assert property (
    neg_channel_out == $past(s_reg.chan_sel[3:0]))
    else $error("mux code differs from the low select bits");
endmodule
`default_nettype wire

// *** verif/acirq_cmp_model.sv ***
// behavioural analog comparator with its positive and negative input selection
`default_nettype none
module acirq_cmp_model (
  input wire logic disable_in,
  input wire logic bandgap_in,
  input wire logic use_chan_in,
  input wire logic [3:0] chan_in,
  input var int pos_mv_in,
  input var int neg_mv_in,
  input var int chan_mv_in,
  output logic result_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BANDGAP_MV = 1180;
  int pos_v;
  int neg_v;
  always_comb begin
    pos_v = bandgap_in ? BANDGAP_MV : pos_mv_in;
    // channel n sits n*100 mv above the base; undefined codes just extend it
    neg_v = use_chan_in ? chan_mv_in + 100 * int'(chan_in)
      : neg_mv_in;
    result_out = !disable_in && (pos_v > neg_v);
  end
endmodule
`default_nettype wire

// *** verif/acirq_top_test.sv ***
// self-checking bench for the comparator control block
`default_nettype none
module acirq_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, rst_in = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0, prdata, r;
  logic pready, pslverr, e, cmp, conv = 1'b0, gie = 1'b0, ack = 1'b0;
  logic dis, bg, use_ch, sup, irq_req, irq;
  logic [3:0] ch;
  int pos_mv = 100, neg_mv = 500, ch_mv = 0;
  int errors = 0, n_compared = 0, cycles = 0;

  acirq_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdat),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cmp_result_in(cmp), .converter_enable_in(conv),
    .global_irq_enable_in(gie), .irq_vector_ack_in(ack),
    .comparator_disable_out(dis), .bandgap_positive_select_out(bg),
    .neg_use_channel_out(use_ch), .neg_channel_out(ch),
    .pin_change_suppress_out(sup), .irq_request_out(irq_req),
    .irq_out(irq));
  acirq_cmp_model i_cmp (.disable_in(dis), .bandgap_in(bg),
    .use_chan_in(use_ch), .chan_in(ch), .pos_mv_in(pos_mv),
    .neg_mv_in(neg_mv), .chan_mv_in(ch_mv), .result_out(cmp));

  initial begin
    forever #50 clk_in = ~clk_in;
  end

  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one full apb transfer; only the bench timeout ends the wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  task automatic t_reset;
    chk(sup, 1'b1);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    chk(e, 1'b0);
    rd(8'h10, 32'h0);
    chk(e, 1'b1);
  endtask

  task automatic t_irq;
    apb(1'b1, 8'h0c, 32'h1);
    apb(1'b1, 8'h00, 32'h03);
    apb(1'b1, 8'h00, 32'h0b);
    pos_mv <= 900;
    wt(6);
    chk(irq_req, 1'b0);
    chk(irq, 1'b1);
    rd(8'h00, 32'h3b);
    gie <= 1'b1;
    wt(2);
    chk(irq_req, 1'b1);
    apb(1'b1, 8'h00, 32'h03);
    wt(1);
    chk(irq_req, 1'b0);
    apb(1'b1, 8'h00, 32'h0b);
    wt(1);
    chk(irq_req, 1'b1);
    ack <= 1'b1;
    @(posedge clk_in);
    ack <= 1'b0;
    wt(1);
    chk(irq_req, 1'b0);
    rd(8'h00, 32'h2b);
    rd(8'h08, 32'h1);
    wt(1);
    chk(irq, 1'b0);
    rd(8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h03);
    gie <= 1'b0;
  endtask

  task automatic t_modes;
    logic [31:0] x;
    apb(1'b1, 8'h00, 32'h01);
    pos_mv <= 100;
    wt(6);
    apb(1'b1, 8'h00, 32'h11);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h00, 32'(m));
      pos_mv <= 900;
      wt(6);
      x = 32'h20 | 32'(m) | ((m == 0 || m == 3) ? 32'h10 : 32'h0);
      rd(8'h00, x);
      apb(1'b1, 8'h00, 32'(m));
      rd(8'h00, x);
      apb(1'b1, 8'h00, 32'h10 | 32'(m));
      pos_mv <= 100;
      wt(6);
      x = 32'(m) | ((m == 0 || m == 2) ? 32'h10 : 32'h0);
      rd(8'h00, x);
      apb(1'b1, 8'h00, 32'h10 | 32'(m));
    end
  endtask

  task automatic t_chan;
    pos_mv <= 300;
    apb(1'b1, 8'h00, 32'h05);
    apb(1'b1, 8'h04, 32'h11);
    @(posedge clk_in);
    chk(ch, 4'h0);
    @(posedge clk_in);
    chk(ch, 4'h1);
    wt(6);
    rd(8'h00, 32'h25);
    conv <= 1'b1;
    wt(6);
    chk(use_ch, 1'b0);
    rd(8'h00, 32'h05);
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b1, 8'h04, 32'h0b);
    wt(2);
    apb(1'b0, 8'h08, 32'h0);
    chk(r & 32'h2, 32'h2);
    conv <= 1'b0;
  endtask

  task automatic t_disable;
    pos_mv <= 900;
    apb(1'b1, 8'h00, 32'h01);
    wt(6);
    apb(1'b1, 8'h00, 32'h81);
    wt(1);
    chk(dis, 1'b1);
    chk(sup, 1'b0);
    rd(8'h00, 32'h81);
    pos_mv <= 100;
    apb(1'b1, 8'h00, 32'h41);
    wt(6);
    chk(bg, 1'b1);
    rd(8'h00, 32'h61);
  endtask

  // a hang past this many cycles ends the run as a failure
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
    end
  end

  initial begin
    wt(6);
    rst_in <= 1'b0;
    t_reset();
    t_irq();
    t_modes();
    t_chan();
    t_disable();
    complete_run();
  end
endmodule
`default_nettype wire
